// ==== rtl/dag_pkg.sv ====
package dag_pkg;

    // Field widths
    localparam int PAGE_W   = 7;   // Main page number width
    localparam int LOCAL_W  = 16;  // Local address width
    localparam int OFF_W    = 7;   // Instruction offset width
    localparam int IOPG_W   = 9;   // I/O page select width
    localparam int DADDR_W  = PAGE_W + LOCAL_W;  // Data-space address width
    localparam int IOADDR_W = IOPG_W + OFF_W;    // I/O address width
    localparam int BIT_W    = 6;   // Register bit index width
    localparam int TGT_W    = 4;   // Register number inside a group

    // Reset values of the pointers
    localparam logic [PAGE_W-1:0]  RST_PAGE  = 7'h00;
    localparam logic [LOCAL_W-1:0] RST_LOCAL = 16'h0000;
    localparam logic [IOPG_W-1:0]  RST_IOPG  = 9'h000;

    // Mapped register area on main page 0
    localparam logic [PAGE_W-1:0]  MMR_PAGE  = 7'h00;
    localparam logic [LOCAL_W-1:0] MMR_LAST  = 16'h005f;

    // Highest bit index of each register size
    localparam logic [BIT_W-1:0]   ACC_TOP   = 6'h27;
    localparam logic [BIT_W-1:0]   WORD_TOP  = 6'h0f;

    // Highest register number of each targetable group
    localparam logic [TGT_W-1:0]   ACC_LAST  = 4'h3;
    localparam logic [TGT_W-1:0]   AUX_LAST  = 4'h7;
    localparam logic [TGT_W-1:0]   TMP_LAST  = 4'h3;

    // Direct addressing kind of the decoded operand
    typedef enum logic [1:0] {
        DM_NONE = 2'b00,
        DM_DATA = 2'b01,
        DM_BIT  = 2'b10,
        DM_IO   = 2'b11
    } dag_mode_t;

    // Register group targeted by a bit operand
    typedef enum logic [1:0] {
        TG_ACC   = 2'b00,
        TG_AUX   = 2'b01,
        TG_TMP   = 2'b10,
        TG_OTHER = 2'b11
    } dag_tgt_t;

endpackage

// ==== rtl/dag_ptr_if.sv ====
`timescale 1ns/1ps
interface dag_ptr_if;
    import dag_pkg::*;

    logic                 wrMainHigh;     // Load main_page_high
    logic                 wrLocalBase;    // Load local_page_base
    logic                 wrExtPage;      // Load extended_page_pointer
    logic                 wrStackHigh;    // Load stack_page_high
    logic                 wrStackBase;    // Load stack_base_low
    logic                 wrExtStack;     // Load extended_stack_pointer
    logic                 wrIoPage;       // Load io_page_select
    logic                 wrModeSel;      // Load direct_mode_select
    logic [DADDR_W-1:0]   wrData;         // Shared write data
    logic [PAGE_W-1:0]    mainPageHigh;   // Current main page
    logic [LOCAL_W-1:0]   localPageBase;  // Current local page base
    logic [PAGE_W-1:0]    stackPageHigh;  // Current stack page
    logic [LOCAL_W-1:0]   stackBaseLow;   // Current stack base
    logic [IOPG_W-1:0]    ioPageSelect;   // Current I/O page
    logic                 directModeSel;  // Current direct mode select

    modport regs (
        input  wrMainHigh, wrLocalBase, wrExtPage, wrStackHigh, wrStackBase,
        input  wrExtStack, wrIoPage, wrModeSel, wrData,
        output mainPageHigh, localPageBase, stackPageHigh, stackBaseLow,
        output ioPageSelect, directModeSel
    );

    modport user (
        output wrMainHigh, wrLocalBase, wrExtPage, wrStackHigh, wrStackBase,
        output wrExtStack, wrIoPage, wrModeSel, wrData,
        input  mainPageHigh, localPageBase, stackPageHigh, stackBaseLow,
        input  ioPageSelect, directModeSel
    );

endinterface // dag_ptr_if

// ==== rtl/dag_ptr_regs.sv ====
`timescale 1ns/1ps
module dag_ptr_regs
    import dag_pkg::*;
(
    input  wire logic clock,    // CPU clock
    input  wire logic sys_rst,  // Asynchronous reset, active high
    dag_ptr_if.regs   ptr       // Pointer write and read side
);

    // All pointer state in one record
    typedef struct packed {
        logic [PAGE_W-1:0]  mainPageHigh;
        logic [LOCAL_W-1:0] localPageBase;
        logic [PAGE_W-1:0]  stackPageHigh;
        logic [LOCAL_W-1:0] stackBaseLow;
        logic [IOPG_W-1:0]  ioPageSelect;
        logic               directModeSel;
    } dag_ptr_t;

    dag_ptr_t state_ff;  // Registered pointers
    dag_ptr_t nxt_state; // Next pointer values

    // Loads: each half alone, or both through the extended pointer
    always_comb begin
        nxt_state = state_ff;
        if (ptr.wrExtPage) begin
            nxt_state.mainPageHigh  = ptr.wrData[DADDR_W-1:LOCAL_W];
            nxt_state.localPageBase = ptr.wrData[LOCAL_W-1:0];
        end else begin
            if (ptr.wrMainHigh) begin
                nxt_state.mainPageHigh = ptr.wrData[PAGE_W-1:0];
            end
            if (ptr.wrLocalBase) begin
                nxt_state.localPageBase = ptr.wrData[LOCAL_W-1:0];
            end
        end
        if (ptr.wrExtStack) begin
            nxt_state.stackPageHigh = ptr.wrData[DADDR_W-1:LOCAL_W];
            nxt_state.stackBaseLow  = ptr.wrData[LOCAL_W-1:0];
        end else begin
            if (ptr.wrStackHigh) begin
                nxt_state.stackPageHigh = ptr.wrData[PAGE_W-1:0];
            end
            if (ptr.wrStackBase) begin
                nxt_state.stackBaseLow = ptr.wrData[LOCAL_W-1:0];
            end
        end
        if (ptr.wrIoPage) begin
            nxt_state.ioPageSelect = ptr.wrData[IOPG_W-1:0];
        end
        if (ptr.wrModeSel) begin
            nxt_state.directModeSel = ptr.wrData[0];
        end
    end

    // Pointer registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= '{RST_PAGE, RST_LOCAL, RST_PAGE, RST_LOCAL, RST_IOPG, 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Present the pointers
    assign ptr.mainPageHigh  = state_ff.mainPageHigh;
    assign ptr.localPageBase = state_ff.localPageBase;
    assign ptr.stackPageHigh = state_ff.stackPageHigh;
    assign ptr.stackBaseLow  = state_ff.stackBaseLow;
    assign ptr.ioPageSelect  = state_ff.ioPageSelect;
    assign ptr.directModeSel = state_ff.directModeSel;

endmodule // dag_ptr_regs

// ==== rtl/direct_address_generator.sv ====
`timescale 1ns/1ps
module direct_address_generator
    import dag_pkg::*;
(
    input  wire logic                clock,         // CPU clock, 200 MHz
    input  wire logic                sys_rst,       // Asynchronous reset, active high
    // Pointer loads from the CPU
    input  wire logic                wrMainHigh,    // Load main page alone
    input  wire logic                wrLocalBase,   // Load local base alone
    input  wire logic                wrExtPage,     // Load both page halves
    input  wire logic                wrStackHigh,   // Load stack page alone
    input  wire logic                wrStackBase,   // Load stack base alone
    input  wire logic                wrExtStack,    // Load both stack halves
    input  wire logic                wrIoPage,      // Load I/O page select
    input  wire logic                wrModeSel,     // Load direct mode select
    input  wire logic [DADDR_W-1:0]  wrData,        // Load data, right aligned
    // Decoded operand
    input  wire dag_mode_t           opMode,        // Direct mode of the operand
    input  wire logic                opRegMap,      // Register-map qualifier
    input  wire logic [OFF_W-1:0]    opOffset,      // Seven-bit word offset
    input  wire logic [BIT_W-1:0]    opBitIndex,    // Bit index of bit operand
    input  wire logic                opBitInstr,    // Instruction is a bit op
    input  wire dag_tgt_t            opTgtGroup,    // Targeted register group
    input  wire logic [TGT_W-1:0]    opTgtNum,      // Register number in group
    // Generated access
    output logic [DADDR_W-1:0]       dataAddr,      // Data-space address
    output logic                     dataValid,     // Data address is live
    output logic                     dataIsStack,   // Data address from stack
    output logic [IOADDR_W-1:0]      ioAddr,        // I/O-space address
    output logic                     ioValid,       // I/O address is live
    output logic [BIT_W-1:0]         bitPos,        // Selected register bit
    output dag_tgt_t                 bitGroup,      // Register group of bit
    output logic [TGT_W-1:0]         bitReg,        // Register number of bit
    output logic                     bitValid,      // Bit target is live
    // Status, one cycle after the operand
    output logic                     opRejected,    // Last operand refused
    output logic                     wrapSeen,      // Last sum wrapped
    output logic                     stackMmrHit,   // Stack touched mapped area
    // Pointer readback
    output logic [DADDR_W-1:0]       extPagePtr,    // Extended page pointer
    output logic [DADDR_W-1:0]       extStackPtr,   // Extended stack pointer
    output logic [IOPG_W-1:0]        ioPageSel,     // I/O page select
    output logic                     modeSel        // Direct mode select
);

    // Status state in one record
    typedef struct packed {
        logic rejected;
        logic wrapped;
        logic mmrHit;
    } dag_stat_t;

    dag_stat_t stat_ff;   // Registered status
    dag_stat_t nxt_stat;  // Next status

    dag_ptr_if ptr ();    // Link to the pointer registers

    // Bases and sums of the data-space path
    logic [PAGE_W-1:0]  selHigh;    // Upper seven address bits
    logic [LOCAL_W-1:0] selBase;    // Base added to the offset
    logic [LOCAL_W:0]   wideSum;    // Sum with carry for wrap sensing
    logic               stackSel;   // Stack direct chosen
    logic               bitLegal;   // Bit operand acceptable
    logic               opLive;     // Some direct operand decoded
    logic               opBad;      // Operand refused

    // Checks a bit index and register number against the group
    function automatic logic bit_ok(input dag_tgt_t grp,
                                    input logic [TGT_W-1:0] num,
                                    input logic [BIT_W-1:0] idx);
        logic ok;
        ok = 1'b0;
        case (grp)
            TG_ACC:  ok = (num <= ACC_LAST) && (idx <= ACC_TOP);
            TG_AUX:  ok = (num <= AUX_LAST) && (idx <= WORD_TOP);
            TG_TMP:  ok = (num <= TMP_LAST) && (idx <= WORD_TOP);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Pointer register bank
    dag_ptr_regs u_ptr_regs (
        .clock   (clock),
        .sys_rst (sys_rst),
        .ptr     (ptr)
    );

    // Forward the loads into the bank
    assign ptr.wrMainHigh  = wrMainHigh;
    assign ptr.wrLocalBase = wrLocalBase;
    assign ptr.wrExtPage   = wrExtPage;
    assign ptr.wrStackHigh = wrStackHigh;
    assign ptr.wrStackBase = wrStackBase;
    assign ptr.wrExtStack  = wrExtStack;
    assign ptr.wrIoPage    = wrIoPage;
    assign ptr.wrModeSel   = wrModeSel;
    assign ptr.wrData      = wrData;

    // Choose page and base for the data-space direct modes
    always_comb begin
        stackSel = ptr.directModeSel;
        if (opRegMap) begin
            // Register-map access: behave as if on page 0, base 0
            selHigh = RST_PAGE;
            selBase = RST_LOCAL;
        end else if (stackSel) begin
            selHigh = ptr.stackPageHigh;
            selBase = ptr.stackBaseLow;
        end else begin
            selHigh = ptr.mainPageHigh;
            selBase = ptr.localPageBase;
        end
    end

    // Sixteen-bit sum; the carry only feeds the wrap flag
    assign wideSum = {1'b0, selBase} + {{(LOCAL_W+1-OFF_W){1'b0}}, opOffset};

    // Data-space address, same cycle as the operand
    always_comb begin
        dataAddr    = {selHigh, wideSum[LOCAL_W-1:0]};
        dataValid   = (opMode == DM_DATA);
        dataIsStack = (opMode == DM_DATA) && stackSel && !opRegMap;
    end

    // I/O address: page select above, offset below
    always_comb begin
        ioAddr  = {ptr.ioPageSelect, opOffset};
        ioValid = (opMode == DM_IO);
    end

    // Bit target from the index, group and register number, valid only for a bit op; no pointer involved
    always_comb begin
        bitLegal = opBitInstr && bit_ok(opTgtGroup, opTgtNum, opBitIndex);
        bitPos   = opBitIndex;
        bitGroup = opTgtGroup;
        bitReg   = opTgtNum;
        bitValid = (opMode == DM_BIT) && bitLegal;
    end

    // Refusal of an operand that cannot be served
    always_comb begin
        opLive = (opMode != DM_NONE);
        opBad  = (opMode == DM_BIT) && !bitLegal;
    end

    // Next status for the cycle after the operand
    always_comb begin
        nxt_stat          = '0;
        nxt_stat.rejected = opLive && opBad;
        // Carry out of bit 15 means the local address wrapped
        nxt_stat.wrapped  = dataValid && wideSum[LOCAL_W];
        // Stack access landing in the mapped-register area of page 0
        nxt_stat.mmrHit   = dataIsStack && (selHigh == MMR_PAGE)
                            && (wideSum[LOCAL_W-1:0] <= MMR_LAST);
    end

    // Status register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // Status and readback outputs
    assign opRejected  = stat_ff.rejected;
    assign wrapSeen    = stat_ff.wrapped;
    assign stackMmrHit = stat_ff.mmrHit;
    assign extPagePtr  = {ptr.mainPageHigh, ptr.localPageBase};
    assign extStackPtr = {ptr.stackPageHigh, ptr.stackBaseLow};
    assign ioPageSel   = ptr.ioPageSelect;
    assign modeSel     = ptr.directModeSel;

endmodule // direct_address_generator

// ==== test/dag_checker_sva.sv ====
`timescale 1ns/1ps
module dag_checker_sva
    import dag_pkg::*;
(
    input  wire logic                 clock,        // CPU clock
    input  wire logic                 sys_rst,      // Async reset
    input  wire logic                 wrMainHigh,   // Main page load
    input  wire logic                 wrLocalBase,  // Local base load
    input  wire logic                 wrExtPage,    // Both page halves
    input  wire logic                 wrExtStack,   // Both stack halves
    input  wire logic [DADDR_W-1:0]   wrData,       // Load data
    input  wire dag_mode_t            opMode,       // Operand mode
    input  wire logic                 opRegMap,     // Map qualifier
    input  wire logic [OFF_W-1:0]     opOffset,     // Word offset
    input  wire logic [BIT_W-1:0]     opBitIndex,   // Bit index
    input  wire logic                 opBitInstr,   // Bit instruction
    input  wire dag_tgt_t             opTgtGroup,   // Target group
    input  wire logic [DADDR_W-1:0]   dataAddr,     // Data address
    input  wire logic                 dataIsStack,  // Stack flag
    input  wire logic [IOADDR_W-1:0]  ioAddr,       // I/O address
    input  wire logic                 ioValid,      // I/O live
    input  wire logic [BIT_W-1:0]     bitPos,       // Bit position
    input  wire logic                 bitValid,     // Bit live
    input  wire logic                 opRejected,   // Refusal pulse
    input  wire logic                 wrapSeen,     // Wrap pulse
    input  wire logic                 stackMmrHit,  // Mapped area pulse
    input  wire logic [DADDR_W-1:0]   extPagePtr,   // Page pointer
    input  wire logic [DADDR_W-1:0]   extStackPtr,  // Stack pointer
    input  wire logic [IOPG_W-1:0]    ioPageSel,    // I/O page
    input  wire logic                 modeSel       // Mode select
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Operand kinds
    sequence s_page;  opMode == DM_DATA && !opRegMap && !modeSel; endsequence
    sequence s_stack; opMode == DM_DATA && !opRegMap && modeSel;  endsequence
    sequence s_bad;   opMode == DM_BIT && (!opBitInstr || opTgtGroup == TG_OTHER); endsequence
    sequence s_carry; (17'(extPagePtr[15:0]) + 17'(opOffset)) > 17'h0ffff; endsequence

    // Single main page load keeps the local half
    property p_highLoad;
        logic [LOCAL_W-1:0] lo;
        logic [PAGE_W-1:0]  hi;
        (wrMainHigh && !wrExtPage && !wrLocalBase, lo = extPagePtr[15:0], hi = wrData[6:0])
            |=> extPagePtr == {hi, lo};
    endproperty

    AST_PAGE_ADDR: assert property (
        s_page |-> !dataIsStack && dataAddr == {extPagePtr[22:16],
        16'(extPagePtr[15:0] + 16'(opOffset))})
        else $error("page direct address wrong");
    AST_STACK_ADDR: assert property (
        s_stack |-> dataIsStack && dataAddr == {extStackPtr[22:16],
        16'(extStackPtr[15:0] + 16'(opOffset))})
        else $error("stack direct address wrong");
    AST_REGMAP: assert property (
        opMode == DM_DATA && opRegMap |-> dataAddr == {16'h0000, opOffset} && !dataIsStack)
        else $error("register map address wrong");
    AST_IO_ADDR: assert property (
        opMode == DM_IO |-> ioValid && ioAddr == {ioPageSel, opOffset})
        else $error("io address wrong");
    AST_BIT_POS: assert property (
        opMode == DM_BIT |-> bitPos == opBitIndex)
        else $error("bit position wrong");
    AST_BIT_REFUSE: assert property (
        s_bad |-> !bitValid ##1 opRejected)
        else $error("bad bit operand accepted");
    AST_WRAP: assert property (
        s_page ##0 s_carry |=> wrapSeen)
        else $error("wrap not flagged");
    AST_EXT_LOAD: assert property (
        wrExtPage |=> extPagePtr == $past(wrData))
        else $error("page pointer load wrong");
    AST_STACK_LOAD: assert property (
        wrExtStack |=> extStackPtr == $past(wrData))
        else $error("stack pointer load wrong");
    AST_HIGH_LOAD: assert property (p_highLoad)
        else $error("main page load wrong");
    AST_MMR_HIT: assert property (
        s_stack ##0 (dataAddr <= 23'h00005f) |=> stackMmrHit)
        else $error("stack mapped area not flagged");
    AST_MMR_CLEAR: assert property (
        opMode != DM_DATA || opRegMap || !modeSel || dataAddr > 23'h00005f |=> !stackMmrHit)
        else $error("stack mapped area flagged wrongly");
endmodule // dag_checker_sva

bind direct_address_generator dag_checker_sva u_sva (.clock(clock), .sys_rst(sys_rst),
    .wrMainHigh(wrMainHigh), .wrLocalBase(wrLocalBase), .wrExtPage(wrExtPage),
    .wrExtStack(wrExtStack), .wrData(wrData), .opMode(opMode), .opRegMap(opRegMap),
    .opOffset(opOffset), .opBitIndex(opBitIndex), .opBitInstr(opBitInstr),
    .opTgtGroup(opTgtGroup), .dataAddr(dataAddr), .dataIsStack(dataIsStack),
    .ioAddr(ioAddr), .ioValid(ioValid), .bitPos(bitPos), .bitValid(bitValid),
    .opRejected(opRejected), .wrapSeen(wrapSeen), .stackMmrHit(stackMmrHit),
    .extPagePtr(extPagePtr),
    .extStackPtr(extStackPtr), .ioPageSel(ioPageSel), .modeSel(modeSel));

// ==== test/dag_bus_model.sv ====
`timescale 1ns/1ps
module dag_bus_model (
    input  wire logic clock,      // CPU clock
    input  wire logic sys_rst,    // Async reset
    input  wire logic dataValid,  // Data access requested
    input  wire logic ioValid,    // I/O access requested
    output int        dataCnt,    // Data accesses served
    output int        ioCnt       // I/O accesses served
);
    // Serve one access per live cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dataCnt <= 0;
            ioCnt   <= 0;
        end else begin
            dataCnt <= dataCnt + int'(dataValid);
            ioCnt   <= ioCnt + int'(ioValid);
        end
    end
endmodule // dag_bus_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import dag_pkg::*;
    logic               clock = 1'b0;      // CPU clock
    logic               sys_rst = 1'b1;    // Reset
    logic [7:0]         wrVec = 8'h00;     // Load pulses by index
    logic [22:0]        wrData = 23'h000000;
    dag_mode_t          opMode = DM_NONE;  // Operand stimulus
    logic               opRegMap = 1'b0;
    logic [6:0]         opOffset = 7'h00;
    logic [5:0]         opBitIndex = 6'h00;
    logic               opBitInstr = 1'b0;
    dag_tgt_t           opTgtGroup = TG_ACC;
    logic [3:0]         opTgtNum = 4'h0;
    logic [22:0]        dataAddr, extPagePtr, extStackPtr;
    logic [15:0]        ioAddr;
    logic [5:0]         bitPos;
    logic [3:0]         bitReg;            // Register number of bit
    dag_tgt_t           bitGroup;          // Register group of bit
    logic [8:0]         ioPageSel;         // I/O page readback
    logic               modeSel;           // Mode select readback
    logic               dataValid, dataIsStack, ioValid, bitValid;
    logic [22:0]        pg, st;            // Expected pointers
    logic [8:0]         io;
    logic               ms;
    logic [25:0]        expQ[$];           // Expected results
    logic [25:0]        note;
    logic [31:0]        rnd = 32'h68d2db6d;
    int                 errorCnt = 0, totalChecks = 0, cyc = 0, nData = 0, nIo = 0;
    int                 dataCnt, ioCnt;

    direct_address_generator uut (.clock(clock), .sys_rst(sys_rst),
        .wrMainHigh(wrVec[0]), .wrLocalBase(wrVec[1]), .wrExtPage(wrVec[2]),
        .wrStackHigh(wrVec[3]), .wrStackBase(wrVec[4]), .wrExtStack(wrVec[5]),
        .wrIoPage(wrVec[6]), .wrModeSel(wrVec[7]), .wrData(wrData), .opMode(opMode),
        .opRegMap(opRegMap), .opOffset(opOffset), .opBitIndex(opBitIndex),
        .opBitInstr(opBitInstr), .opTgtGroup(opTgtGroup), .opTgtNum(opTgtNum),
        .dataAddr(dataAddr), .dataValid(dataValid), .dataIsStack(dataIsStack),
        .ioAddr(ioAddr), .ioValid(ioValid), .bitPos(bitPos), .bitGroup(bitGroup),
        .bitReg(bitReg),
        .bitValid(bitValid), .opRejected(), .wrapSeen(), .stackMmrHit(),
        .extPagePtr(extPagePtr), .extStackPtr(extStackPtr), .ioPageSel(ioPageSel),
        .modeSel(modeSel));
    dag_bus_model bus (.clock(clock), .sys_rst(sys_rst), .dataValid(dataValid),
        .ioValid(ioValid), .dataCnt(dataCnt), .ioCnt(ioCnt));

    // Clock generator
    initial forever #2.5 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task check(input string nm, input logic [23:0] e, input logic [23:0] g);
        totalChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task endOfTest;
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One-cycle pointer load, operand dropped meanwhile
    task wr(input int i, input logic [22:0] d);
        @(posedge clock);
        opMode <= DM_NONE;
        wrVec[i] <= 1'b1;
        wrData <= d;
        @(posedge clock);
        wrVec <= 8'h00;
        case (i)
            0: pg[22:16] = d[6:0];
            1: pg[15:0] = d[15:0];
            2: pg = d;
            3: st[22:16] = d[6:0];
            4: st[15:0] = d[15:0];
            5: st = d;
            6: io = d[8:0];
            default: ms = d[0];
        endcase
    endtask

    // Present one operand for one cycle and note its result
    task op(input dag_mode_t m, input logic rm, input logic [6:0] off, input logic [5:0] bi,
            input logic bo, input dag_tgt_t g, input logic [3:0] n);
        logic [23:0] e;
        logic        ok;
        @(posedge clock);
        {opRegMap, opOffset, opBitIndex, opBitInstr, opTgtGroup, opTgtNum} <= {rm, off, bi, bo, g, n};
        opMode <= m;
        ok = bo && (g == TG_ACC ? n <= ACC_LAST && bi <= ACC_TOP :
             g == TG_AUX ? n <= AUX_LAST && bi <= WORD_TOP :
             g == TG_TMP ? n <= TMP_LAST && bi <= WORD_TOP : 1'b0);
        case (m)
            DM_DATA: e = rm ? {17'h00000, off} : ms ? {1'b1, st[22:16], 16'(st[15:0] + off)}
                                                    : {1'b0, pg[22:16], 16'(pg[15:0] + off)};
            DM_IO:   e = {8'h00, io, off};
            default: e = {11'h000, g, n, ok, bi};
        endcase
        nData += int'(m == DM_DATA);
        nIo += int'(m == DM_IO);
        expQ.push_back({m, e});
    endtask

    task d(input dag_mode_t m, input logic rm, input logic [6:0] off);
        op(m, rm, off, 6'h00, 1'b0, TG_ACC, 4'h0);
    endtask

    // Result monitor, compares against the oldest note
    always @(negedge clock) begin
        if (opMode != DM_NONE && expQ.size() > 0) begin
            note = expQ.pop_front();
            case (note[25:24])
                DM_DATA: check("dataAddr", note[23:0], {dataIsStack, dataAddr});
                DM_IO:   check("ioAddr", note[23:0], {8'h00, ioAddr});
                default: check("bitTarget", note[23:0],
                               {11'h000, bitGroup, bitReg, bitValid, bitPos});
            endcase
        end
    end

    // Hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errorCnt++;
            endOfTest;
        end
    end

    initial begin
        {pg, st, io, ms} = '0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        d(DM_DATA, 1'b0, 7'h05);
        d(DM_IO, 1'b0, 7'h7f);
        wr(2, 23'h03fff0);
        d(DM_DATA, 1'b0, 7'h04);
        d(DM_DATA, 1'b0, 7'h7f);
        d(DM_DATA, 1'b1, 7'h10);
        wr(0, 23'h00007f);
        wr(1, 23'h000123);
        d(DM_DATA, 1'b0, 7'((16'h0150 - 16'h0123) & 16'h007f));
        wr(5, 23'h010060);
        wr(7, 23'h000001);
        d(DM_DATA, 1'b0, 7'h7f);
        d(DM_DATA, 1'b1, 7'h22);
        wr(3, 23'h000000);
        wr(4, 23'h000060);
        d(DM_DATA, 1'b0, 7'h01);
        wr(6, 23'h0001ff);
        d(DM_IO, 1'b0, 7'h7f);
        op(DM_BIT, 1'b0, 7'h00, 6'h27, 1'b1, TG_ACC, 4'h3);
        op(DM_BIT, 1'b0, 7'h00, 6'h28, 1'b1, TG_ACC, 4'h3);
        op(DM_BIT, 1'b0, 7'h00, 6'h0f, 1'b1, TG_AUX, 4'h7);
        op(DM_BIT, 1'b0, 7'h00, 6'h10, 1'b1, TG_TMP, 4'h3);
        op(DM_BIT, 1'b0, 7'h00, 6'h00, 1'b1, TG_TMP, 4'h4);
        op(DM_BIT, 1'b0, 7'h00, 6'h00, 1'b0, TG_AUX, 4'h0);
        wr(7, 23'h000000);
        d(DM_IO, 1'b0, 7'h00);
        for (int i = 0; i < 30; i++) begin
            rnd = lfsr(rnd);
            op(DM_BIT, 1'b0, rnd[6:0], rnd[12:7], rnd[13], dag_tgt_t'(rnd[15:14]), rnd[19:16]);
            wr(2, rnd[22:0]);
            rnd = lfsr(rnd);
            wr(5, {rnd[22:16] | 7'h01, rnd[15:0]});
            wr(7, {22'h000000, rnd[31]});
            d(DM_DATA, rnd[30], rnd[6:0]);
            d(DM_IO, 1'b0, rnd[29:23]);
        end
        wr(6, 23'h000000);
        repeat (3) @(posedge clock);
        check("dataCnt", 24'(nData), 24'(dataCnt));
        check("ioCnt", 24'(nIo), 24'(ioCnt));
        check("extPagePtr", 24'(pg), 24'(extPagePtr));
        check("extStackPtr", 24'(st), 24'(extStackPtr));
        check("ioPageSel", 24'(io), 24'(ioPageSel));
        check("modeSel", 24'(ms), 24'(modeSel));
        endOfTest;
    end
endmodule // testbench
